// *** rtl/tsm_consts.svh ***
// Purpose: Offsets, fields, codes and fixed options of the table access guard
// Assumes: Byte addresses on a 32-bit AXI4-Lite register port
// Notes: Definitions only
`ifndef TSM_CONSTS_SVH
`define TSM_CONSTS_SVH

// ==========================================================
// Register offsets
`define TSM_ID_OFF 12'h000
`define TSM_PIDR_OFF 12'h004
`define TSM_IST_OFF 12'h008
`define TSM_IMSK_OFF 12'h00c
`define TSM_ERR_OFF 12'h010
`define TSM_CTRL_OFF 12'h014
`define TSM_DOM_OFF 12'h040
`define TSM_DOM_END 12'h07f
`define TSM_DPART_OFF 4'h0
`define TSM_DRBASE_OFF 4'h4
`define TSM_DRLIM_OFF 4'h8

// ==========================================================
// Fixed options and identification fields
`define TSM_HAS_PART 1'b1
`define TSM_HAS_SP 1'b1
`define TSM_HAS_REALM 1'b1
`define TSM_PARTITION_ID_MAX 16'h00ff
`define TSM_MONITOR_GROUP_MAX 8'h01

// ==========================================================
// Status bits, error classes, access shape, system map
`define TSM_ST_PCIE 0
`define TSM_ST_REGION 1
`define TSM_ST_ALIGN 2
`define TSM_ST_ABORT 3
`define TSM_EC_NONE 3'h0
`define TSM_EC_PCIE 3'h1
`define TSM_EC_REGION 3'h2
`define TSM_EC_ALIGN 3'h3
`define TSM_EC_ABORT 3'h4
`define TSM_MIN_LSIZE 3'h3
`define TSM_PCIE_BASE 32'h4000_0000
`define TSM_PCIE_LIMIT 32'h7fff_ffff
`define TSM_RESP_OK 2'h0
`define TSM_RESP_SLVERR 2'h2

`endif

// *** rtl/tsm_pkg.sv ***
// Purpose: Types of the table access guard
// Assumes: Constants come from tsm_consts.svh
// Notes: Domain and space share one encoding
package tsm_pkg;

  typedef enum logic [1:0] {DOM_SEC, DOM_NS, DOM_ROOT, DOM_REALM} tsm_dom_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_DONE} tsm_state_t;

  typedef struct packed {
    logic [31:0] addr;
    tsm_dom_t dom;
    logic [2:0] lsize;
    logic evt;
  } tsm_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] lsize;
    logic ns_attr;
    tsm_dom_t space;
    logic [15:0] partition_identifier;
    logic [7:0] monitoring_group;
  } tsm_mreq_t;

  typedef struct packed {
    logic err;
    logic drop;
    logic [2:0] code;
    logic [63:0] data;
  } tsm_res_t;

endpackage

// *** rtl/tsm_guard.sv ***
// Purpose: Guards translation-table memory accesses and tags them
// Assumes: Engine and memory run on aclk; AXI4-Lite register port
// Notes: One table access at a time
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "tsm_consts.svh"

// Summary of operation
// - PCIe-space table access terminated with error
// - Such a failed translation is dropped
// - Check address against own domain's region
// - Only register-derived addresses are issued
// - Invalid region flag blocks any access
// - Accesses at least 64-bit, 8-byte aligned, atomic
// - External abort stops, error class 0x04
// - Abort during translation drops the event
// - Overlap never escapes domain region
// - Flags and widths advertise partitioning
// - Per-domain partition id and group tagged
// - Space signalled by nonsecure or select attribute
// - No realm: secure, root to secure
// - Realm: each domain to own space
// - Select bit set: programmed space used
// - Without partitioning, tags are zero
module tsm_guard (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Table access request from translation engine
  input wire tsm_pkg::tsm_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  // Result back to translation engine
  output tsm_pkg::tsm_res_t res,
  output logic res_valid,
  // Memory request and response
  output tsm_pkg::tsm_mreq_t mreq,
  output logic mreq_valid,
  input wire logic mreq_ready,
  input wire logic [63:0] mrsp_data,
  input wire logic mrsp_abort,
  input wire logic mrsp_valid,
  output logic mrsp_ready,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [32:0] last_byte(input logic [31:0] a, input logic [2:0] ls);
    logic [32:0] sz;
    sz = 33'h1 << ls;
    return {1'b0, a} + sz - 33'h1;
  endfunction

  // Default space per domain when no explicit select is used
  function automatic tsm_pkg::tsm_dom_t def_space(input tsm_pkg::tsm_dom_t d,
                                                  input logic realm);
    case (d)
      tsm_pkg::DOM_SEC: def_space = tsm_pkg::DOM_SEC;
      tsm_pkg::DOM_NS: def_space = tsm_pkg::DOM_NS;
      tsm_pkg::DOM_ROOT: def_space = realm ? tsm_pkg::DOM_ROOT : tsm_pkg::DOM_SEC;
      tsm_pkg::DOM_REALM: def_space = realm ? tsm_pkg::DOM_REALM : tsm_pkg::DOM_SEC;
      default: def_space = tsm_pkg::DOM_SEC;
    endcase
  endfunction

  // ==========================================================
  // Registers
  logic [31:0] part_reg [4];
  logic [31:0] rbase_reg [4];
  logic [31:0] rlim_reg [4];
  logic [3:0] ist_reg;
  logic [3:0] imsk_reg;
  logic [2:0] ec_reg;
  logic ecv_reg;
  logic en_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic wr_go;
  logic wr_ok;
  logic [3:0] ev_set;
  tsm_pkg::tsm_state_t st_reg;
  tsm_pkg::tsm_req_t cur_reg;

  // ==========================================================
  // AXI4-Lite write: address and data taken in either order
  assign s_awready = ce && !aw_got_reg && !s_bvalid;
  assign s_wready = ce && !w_got_reg && !s_bvalid;
  assign wr_go = ce && aw_got_reg && w_got_reg && !s_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_wdata;
        wstrb_reg <= s_wstrb;
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_ok = 1'b0;
    case ({awaddr_reg[11:2], 2'h0})
      `TSM_IST_OFF, `TSM_IMSK_OFF, `TSM_CTRL_OFF: wr_ok = 1'b1;
      default: wr_ok = awaddr_reg >= `TSM_DOM_OFF && awaddr_reg <= `TSM_DOM_END
                       && awaddr_reg[3:2] != 2'h3;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= `TSM_RESP_OK;
    end else if (ce) begin
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? `TSM_RESP_OK : `TSM_RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Per-domain partition and region registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int d = 0; d < 4; d++) begin
        part_reg[d] <= 32'h0000_0000;
        rbase_reg[d] <= 32'h0000_0000;
        rlim_reg[d] <= 32'h0000_0000;
      end
    end else if (ce && wr_go && wr_ok && awaddr_reg >= `TSM_DOM_OFF) begin
      case (awaddr_reg[3:0])
        `TSM_DPART_OFF: part_reg[awaddr_reg[5:4]] <=
            merge(part_reg[awaddr_reg[5:4]], wdata_reg, wstrb_reg);
        `TSM_DRBASE_OFF: rbase_reg[awaddr_reg[5:4]] <=
            merge(rbase_reg[awaddr_reg[5:4]], wdata_reg, wstrb_reg);
        `TSM_DRLIM_OFF: rlim_reg[awaddr_reg[5:4]] <=
            merge(rlim_reg[awaddr_reg[5:4]], wdata_reg, wstrb_reg);
        default: ;
      endcase
    end
  end

  // Control, mask, sticky status (set wins over clear)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_reg <= 1'b0;
      imsk_reg <= 4'h0;
      ist_reg <= 4'h0;
    end else if (ce) begin
      if (wr_go && awaddr_reg == `TSM_CTRL_OFF && wstrb_reg[0]) begin
        en_reg <= wdata_reg[0];
      end
      if (wr_go && awaddr_reg == `TSM_IMSK_OFF && wstrb_reg[0]) begin
        imsk_reg <= wdata_reg[3:0];
      end
      if (wr_go && awaddr_reg == `TSM_IST_OFF && wstrb_reg[0]) begin
        ist_reg <= (ist_reg & ~wdata_reg[3:0]) | ev_set;
      end else begin
        ist_reg <= ist_reg | ev_set;
      end
    end
  end

  assign irq = |(ist_reg & imsk_reg);

  // ==========================================================
  // AXI4-Lite read
  assign s_arready = ce && !s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `TSM_RESP_OK;
    end else if (ce) begin
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp <= `TSM_RESP_OK;
        s_rdata <= 32'h0000_0000;
        case ({s_araddr[11:2], 2'h0})
          `TSM_ID_OFF: s_rdata <= {29'h0, `TSM_HAS_REALM, `TSM_HAS_SP, `TSM_HAS_PART};
          `TSM_PIDR_OFF: s_rdata <= `TSM_HAS_PART ?
              {7'h0, `TSM_HAS_SP, `TSM_MONITOR_GROUP_MAX, `TSM_PARTITION_ID_MAX} : 32'h0000_0000;
          `TSM_IST_OFF: s_rdata <= {28'h0, ist_reg};
          `TSM_IMSK_OFF: s_rdata <= {28'h0, imsk_reg};
          `TSM_ERR_OFF: s_rdata <= {ecv_reg, 28'h0, ec_reg};
          `TSM_CTRL_OFF: s_rdata <= {30'h0, st_reg != tsm_pkg::ST_IDLE, en_reg};
          default: begin
            if (s_araddr >= `TSM_DOM_OFF && s_araddr <= `TSM_DOM_END) begin
              case ({s_araddr[3:2], 2'h0})
                `TSM_DPART_OFF: s_rdata <= part_reg[s_araddr[5:4]];
                `TSM_DRBASE_OFF: s_rdata <= rbase_reg[s_araddr[5:4]];
                `TSM_DRLIM_OFF: s_rdata <= rlim_reg[s_araddr[5:4]];
                default: s_rresp <= `TSM_RESP_SLVERR;
              endcase
            end else begin
              s_rresp <= `TSM_RESP_SLVERR;
            end
          end
        endcase
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Access checks on the incoming request
  logic [32:0] req_last;
  logic in_pcie;
  logic in_region;
  logic bad_shape;
  logic [2:0] chk_ec;

  assign req_last = last_byte(req.addr, req.lsize);
  assign in_pcie = req.addr <= `TSM_PCIE_LIMIT && req_last >= {1'b0, `TSM_PCIE_BASE};
  // Only the issuing domain's own region is consulted
  assign in_region = rlim_reg[req.dom][0]
                     && req.addr >= rbase_reg[req.dom]
                     && req_last <= {1'b0, rlim_reg[req.dom][31:3], 3'h7};
  assign bad_shape = req.lsize < `TSM_MIN_LSIZE || req.addr[2:0] != 3'h0;
  assign chk_ec = in_pcie ? `TSM_EC_PCIE : bad_shape ? `TSM_EC_ALIGN :
                  !in_region ? `TSM_EC_REGION : `TSM_EC_NONE;

  assign req_ready = ce && en_reg && st_reg == tsm_pkg::ST_IDLE;
  // Valids follow the enable too, so a frozen block is never taken twice
  assign mreq_valid = ce && st_reg == tsm_pkg::ST_ISSUE;
  assign mrsp_ready = ce && st_reg == tsm_pkg::ST_WAIT;
  assign res_valid = ce && st_reg == tsm_pkg::ST_DONE;

  // ==========================================================
  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= tsm_pkg::ST_IDLE;
      cur_reg <= '0;
      res <= '0;
    end else if (ce) begin
      case (st_reg)
        tsm_pkg::ST_IDLE: begin
          if (req_valid && req_ready) begin
            cur_reg <= req;
            res <= '0;
            if (chk_ec != `TSM_EC_NONE) begin
              res.err <= 1'b1;
              res.code <= chk_ec;
              res.drop <= req.evt;
              st_reg <= tsm_pkg::ST_DONE;
            end else begin
              st_reg <= tsm_pkg::ST_ISSUE;
            end
          end
        end
        tsm_pkg::ST_ISSUE: begin
          if (mreq_ready) begin
            st_reg <= tsm_pkg::ST_WAIT;
          end
        end
        tsm_pkg::ST_WAIT: begin
          if (mrsp_valid) begin
            res.data <= mrsp_data;
            res.err <= mrsp_abort;
            res.code <= mrsp_abort ? `TSM_EC_ABORT : `TSM_EC_NONE;
            res.drop <= mrsp_abort && cur_reg.evt;
            st_reg <= tsm_pkg::ST_DONE;
          end
        end
        tsm_pkg::ST_DONE: st_reg <= tsm_pkg::ST_IDLE;
        default: st_reg <= tsm_pkg::ST_IDLE;
      endcase
    end
  end

  // Event flags and last error class
  always_comb begin
    ev_set = 4'h0;
    if (res_valid && res.err) begin
      case (res.code)
        `TSM_EC_PCIE: ev_set[`TSM_ST_PCIE] = 1'b1;
        `TSM_EC_REGION: ev_set[`TSM_ST_REGION] = 1'b1;
        `TSM_EC_ALIGN: ev_set[`TSM_ST_ALIGN] = 1'b1;
        default: ev_set[`TSM_ST_ABORT] = 1'b1;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ec_reg <= `TSM_EC_NONE;
      ecv_reg <= 1'b0;
    end else if (ce && res_valid && res.err) begin
      ec_reg <= res.code;
      ecv_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Memory request with partition tags
  tsm_pkg::tsm_dom_t sp;
  logic [31:0] cur_part;

  assign cur_part = part_reg[cur_reg.dom];
  assign sp = `TSM_HAS_SP ? tsm_pkg::tsm_dom_t'(cur_part[25:24])
              : def_space(cur_reg.dom, `TSM_HAS_REALM);

  always_comb begin
    mreq.addr = cur_reg.addr;
    mreq.lsize = cur_reg.lsize;
    mreq.space = sp;
    mreq.ns_attr = sp == tsm_pkg::DOM_NS;
    // Tags are zero when partitioning is not built
    mreq.partition_identifier = `TSM_HAS_PART ? cur_part[15:0] : 16'h0000;
    mreq.monitoring_group = `TSM_HAS_PART ? cur_part[23:16] : 8'h00;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pcie_never: assert property (req_valid && req_ready && in_pcie
      |=> st_reg == tsm_pkg::ST_DONE && res.err)
    else $error("PCIe access not terminated");
  a_err_drop: assert property (res_valid && res.err && cur_reg.evt |-> res.drop)
    else $error("failed translation not dropped");
  a_region_ok: assert property (st_reg == tsm_pkg::ST_IDLE
      |=> st_reg != tsm_pkg::ST_ISSUE || $past(rlim_reg[req.dom][0]))
    else $error("access issued without valid region");
  a_mem_shape: assert property (mreq_valid |-> mreq.addr[2:0] == 3'h0 && mreq.lsize >= 3'h3)
    else $error("table access not 64-bit aligned");
  a_abort_code: assert property (st_reg == tsm_pkg::ST_WAIT && mrsp_valid && mrsp_abort && ce
      |=> st_reg == tsm_pkg::ST_DONE && res.err && res.code == 3'h4)
    else $error("abort not reported with class 4");
  a_code_range: assert property (res_valid |-> res.code <= 3'h4)
    else $error("error class out of range");
  a_abort_drop: assert property (st_reg == tsm_pkg::ST_WAIT && mrsp_valid && mrsp_abort
      && ce && cur_reg.evt |=> res.drop)
    else $error("aborted translation not dropped");
  a_mreq_hold: assert property (mreq_valid && !mreq_ready
      |=> st_reg == tsm_pkg::ST_ISSUE && $stable(mreq.addr))
    else $error("memory request changed before taken");
  a_part_tag: assert property (mreq_valid |-> mreq.partition_identifier == part_reg[cur_reg.dom][15:0]
      && mreq.monitoring_group == part_reg[cur_reg.dom][23:16])
    else $error("partition tags not from issuing domain");
  a_irq_level: assert property (ce && |(ev_set & imsk_reg) |=> irq)
    else $error("unmasked event did not raise interrupt");

endmodule

// *** testbench/tsm_mem_model.sv ***
// Purpose: Memory side partner of the table access guard
// Assumes: One access at a time, one 64-bit word each
// Notes: Read data is {~addr, addr}; slow adds wait cycles
`timescale 1ns/1ps
module tsm_mem_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request
  input wire tsm_pkg::tsm_mreq_t mreq,
  input wire logic mreq_valid,
  output logic mreq_ready,
  // Response
  output logic [63:0] mrsp_data,
  output logic mrsp_abort,
  output logic mrsp_valid,
  input wire logic mrsp_ready,
  // Behaviour select
  input wire logic slow,
  input wire logic abort_en
);
  logic pend;
  logic [2:0] cnt;
  logic [31:0] a;
  // ==========================================
  // Accept and answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mreq_ready <= 1'b0;
      mrsp_valid <= 1'b0;
      pend <= 1'b0;
      cnt <= 3'h0;
      mrsp_data <= 64'h0;
      mrsp_abort <= 1'b0;
      a <= 32'h0;
    end else begin
      mreq_ready <= 1'b0;
      if (!mrsp_valid) begin
        // Idle lines toggle so stale data is never read as good
        mrsp_data <= ~mrsp_data;
        mrsp_abort <= ~mrsp_abort;
      end else if (mrsp_ready) begin
        mrsp_valid <= 1'b0;
      end
      if (mreq_valid && !mreq_ready && !pend) begin
        cnt <= cnt + 3'h1;
        if (cnt >= {slow, 2'h0}) begin
          mreq_ready <= 1'b1;
          pend <= 1'b1;
          a <= mreq.addr;
          cnt <= 3'h0;
        end
      end else if (pend) begin
        cnt <= cnt + 3'h1;
        if (cnt >= {slow, 2'h0}) begin
          mrsp_valid <= 1'b1;
          mrsp_data <= {~a, a};
          mrsp_abort <= abort_en;
          pend <= 1'b0;
          cnt <= 3'h0;
        end
      end
    end
  end
endmodule

// *** testbench/tsm_guard_tb_top.sv ***
// Purpose: Self-checking bench of the table access guard
// Assumes: Memory side is tsm_mem_model
// Notes: Results packed as {err, drop, code}
`timescale 1ns/1ps
`include "tsm_consts.svh"
module tsm_guard_tb_top;
  logic aclk, aresetn, ce, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, req_valid, req_ready, res_valid;
  logic mreq_valid, mreq_ready, mrsp_abort, mrsp_valid, mrsp_ready, irq, slow, abort_en;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [63:0] mrsp_data;
  tsm_pkg::tsm_req_t req;
  tsm_pkg::tsm_res_t res;
  tsm_pkg::tsm_mreq_t mreq, lm;
  int checks, miscompares, n_mreq;
  logic [31:0] base [4] = '{32'h1000_0000, 32'h3fff_0000, 32'h2000_0000, 32'h3000_0000};

  tsm_guard u_tsm_guard (.aclk, .aresetn, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .req, .req_valid, .req_ready, .res,
    .res_valid, .mreq, .mreq_valid, .mreq_ready, .mrsp_data, .mrsp_abort, .mrsp_valid,
    .mrsp_ready, .irq);
  tsm_mem_model u_tsm_mem_model (.aclk, .aresetn, .mreq, .mreq_valid, .mreq_ready, .mrsp_data,
    .mrsp_abort, .mrsp_valid, .mrsp_ready, .slow, .abort_en);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Memory accesses actually issued
  always @(posedge aclk) begin
    if (mreq_valid && mreq_ready) begin
      n_mreq++;
      lm = mreq;
    end
  end

  // ==========================================
  // Checking and closing
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // A wait that runs out counts as one mismatch
  task automatic timeout();
    check(1'b0, 1'b1);
    print_verdict();
  endtask

  // ==========================================
  // Register bus master
  function automatic logic [11:0] dof(int d, int o);
    return 12'(64 + 16 * d + o);
  endfunction

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
    int n = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!(s_bvalid && s_bready) && n < 50);
    if (n >= 50) timeout();
    rsp = s_bresp;
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [11:0] a);
    int n = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!(s_rvalid && s_rready) && n < 50);
    if (n >= 50) timeout();
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // ==========================================
  // Engine side: one table access, result checked
  task automatic eng(input logic [31:0] a, input tsm_pkg::tsm_dom_t d, input logic [2:0] ls,
                     input logic ev, input logic [4:0] exp);
    int n = 0;
    int m = n_mreq;
    req <= '{addr: a, dom: d, lsize: ls, evt: ev};
    req_valid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!req_ready && n < 50);
    req_valid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!res_valid && n < 100);
    if (n >= 100) timeout();
    check({res.err, res.drop, res.code}, exp);
    check(64'(n_mreq - m), (exp[2:0] == 3'h0 || exp[2:0] == 3'h4) ? 1 : 0);
    if (exp == 5'h0) check(res.data, {~a, a});
  endtask

  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, req_valid} = 6'h0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    req = '0;
    {slow, abort_en} = 2'h0;
    {checks, miscompares, n_mreq} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`TSM_ID_OFF);
    check(rd, 32'h7);
    axi_rd(`TSM_PIDR_OFF);
    check(rd, 32'h0101_00ff);
    axi_rd(`TSM_CTRL_OFF);
    check(rd, 32'h0);
    axi_rd(dof(0, 12));
    check(rsp, `TSM_RESP_SLVERR);
    for (int d = 0; d < 4; d++) begin
      axi_wr(dof(d, 0), {6'h0, 2'(3 - d), 8'(d + 1), 16'(16 + d)}, 4'hf);
      axi_wr(dof(d, 4), base[d], 4'hf);
      axi_wr(dof(d, 8), base[d] + 32'hfff9, 4'hf);
    end
    axi_wr(`TSM_CTRL_OFF, 32'h1, 4'hf);
    check(rsp, `TSM_RESP_OK);
    // Each domain tagged with its own programmed values, fast and slow memory
    for (int d = 0; d < 4; d++) begin
      slow <= d[0];
      eng(base[d] + 32'h8, tsm_pkg::tsm_dom_t'(d), 3'h3, 1'b1, 5'h0);
      check(lm.addr, base[d] + 32'h8);
      check(lm.lsize, 3'h3);
      check({lm.space, lm.monitoring_group, lm.partition_identifier}, {2'(3 - d), 8'(d + 1), 16'(16 + d)});
      check(lm.ns_attr, 2'(3 - d) == 2'h1);
    end
    eng(base[2] + 32'hfff8, tsm_pkg::DOM_ROOT, 3'h3, 1'b0, 5'h0);
    eng(base[2] + 32'h10000, tsm_pkg::DOM_ROOT, 3'h3, 1'b1, 5'h1a);
    eng(base[0] + 32'h8, tsm_pkg::DOM_NS, 3'h3, 1'b1, 5'h1a);
    eng(32'h4000_0000, tsm_pkg::DOM_NS, 3'h3, 1'b1, 5'h19);
    eng(32'h4000_0008, tsm_pkg::DOM_NS, 3'h3, 1'b0, 5'h11);
    eng(base[0] + 32'h8, tsm_pkg::DOM_SEC, 3'h2, 1'b0, 5'h13);
    eng(base[0] + 32'h4, tsm_pkg::DOM_SEC, 3'h3, 1'b1, 5'h1b);
    axi_wr(dof(3, 8), base[3] + 32'hfff8, 4'hf);
    eng(base[3] + 32'h8, tsm_pkg::DOM_REALM, 3'h3, 1'b1, 5'h1a);
    abort_en <= 1'b1;
    eng(base[0] + 32'h8, tsm_pkg::DOM_SEC, 3'h3, 1'b1, 5'h1c);
    eng(base[0] + 32'h10, tsm_pkg::DOM_SEC, 3'h3, 1'b0, 5'h14);
    abort_en <= 1'b0;
    axi_rd(`TSM_ERR_OFF);
    check(rd, 32'h8000_0004);
    // Sticky status, mask, level interrupt
    axi_rd(`TSM_IST_OFF);
    check(rd, 32'hf);
    check(irq, 1'b0);
    axi_wr(`TSM_IMSK_OFF, 32'h8, 4'hf);
    check(irq, 1'b1);
    axi_wr(`TSM_IST_OFF, 32'h8, 4'hf);
    check(irq, 1'b0);
    axi_rd(`TSM_IST_OFF);
    check(rd, 32'h7);
    axi_wr(`TSM_IMSK_OFF, 32'h4, 4'h0);
    axi_rd(`TSM_IMSK_OFF);
    check(rd, 32'h8);
    // Enable low freezes the block and drops every ready
    ce <= 1'b0;
    @(posedge aclk);
    check({s_awready, s_wready, s_arready, req_ready}, 4'h0);
    ce <= 1'b1;
    // Recovery: disable, rewrite the limit with the valid bit set, enable again
    axi_wr(`TSM_CTRL_OFF, 32'h0, 4'hf);
    check(req_ready, 1'b0);
    axi_wr(dof(3, 8), base[3] + 32'hfff9, 4'hf);
    axi_wr(`TSM_CTRL_OFF, 32'h1, 4'hf);
    eng(base[3] + 32'h8, tsm_pkg::DOM_REALM, 3'h3, 1'b1, 5'h0);
    print_verdict();
  end
endmodule
